// File: rtl/twm_defines.svh
// Register offsets, field positions and timing counts of the two-wire master
`ifndef TWM_DEFINES_SVH
`define TWM_DEFINES_SVH
`define TWM_OFF_TASK_RX_BEGIN   12'h000
`define TWM_OFF_TASK_TX_BEGIN   12'h008
`define TWM_OFF_TASK_HALT       12'h014
`define TWM_OFF_TASK_PAUSE      12'h01C
`define TWM_OFF_TASK_CONTINUE   12'h020
`define TWM_OFF_EV_HALTED       12'h104
`define TWM_OFF_EV_FAULT        12'h124
`define TWM_OFF_EV_PAUSED       12'h148
`define TWM_OFF_EV_RX_BEGUN     12'h14C
`define TWM_OFF_EV_TX_BEGUN     12'h150
`define TWM_OFF_EV_FINAL_RX     12'h15C
`define TWM_OFF_EV_FINAL_TX     12'h160
`define TWM_OFF_LINKS           12'h200
`define TWM_OFF_IRQ_EN          12'h300
`define TWM_OFF_IRQ_SET         12'h304
`define TWM_OFF_IRQ_CLR         12'h308
`define TWM_OFF_FAULT_CAUSE     12'h4C4
`define TWM_OFF_ENABLE          12'h500
`define TWM_OFF_SCL_SEL         12'h508
`define TWM_OFF_SDA_SEL         12'h50C
`define TWM_OFF_RATE            12'h524
`define TWM_OFF_RX_PTR          12'h534
`define TWM_OFF_RX_LIMIT        12'h538
`define TWM_OFF_RX_MOVED        12'h53C
`define TWM_OFF_RX_LIST         12'h540
`define TWM_OFF_TX_PTR          12'h544
`define TWM_OFF_TX_LIMIT        12'h548
`define TWM_OFF_TX_MOVED        12'h54C
`define TWM_OFF_TX_LIST         12'h550
`define TWM_OFF_ADDR            12'h588
`define TWM_LINK_TX_RX          7
`define TWM_LINK_TX_PAUSE       8
`define TWM_LINK_TX_HALT        9
`define TWM_LINK_RX_TX          10
`define TWM_LINK_RX_HALT        12
`define TWM_IE_HALTED           1
`define TWM_IE_FAULT            9
`define TWM_IE_PAUSED           18
`define TWM_IE_RX_BEGUN         19
`define TWM_IE_TX_BEGUN         20
`define TWM_IE_FINAL_RX         23
`define TWM_IE_FINAL_TX         24
`define TWM_IE_MASK             32'h01DC0202
`define TWM_ENABLE_ON           4'h6
`define TWM_SEL_RESET           32'hFFFFFFFF
`define TWM_RATE_RESET          32'h04000000
`define TWM_FAULT_ADDR_NACK     1
`define TWM_FAULT_DATA_NACK     2
`define TWM_CLK_MHZ             125
`define TWM_QTR_NS              2500
`define TWM_QTR_CYC             ((`TWM_QTR_NS * `TWM_CLK_MHZ) / 1000)
`endif

// File: rtl/twm_pkg.sv
// Types shared by the two-wire master
package twm_pkg;
	typedef enum {
		ST_IDLE, ST_START, ST_BIT, ST_ACK, ST_NEXT, ST_HOLD, ST_STOP, ST_DONE
	} twm_phase_type;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [11:0] adr;
		logic [31:0] dat;
	} twm_wb_req_type;

	typedef struct packed {
		logic        we;
		logic [31:0] adr;
		logic [7:0]  dat;
	} twm_mem_req_type;

	typedef struct packed {
		logic scl_o;
		logic scl_oe;
		logic sda_o;
		logic sda_oe;
	} twm_pin_type;
endpackage : twm_pkg

// File: rtl/twm_master.sv
// Two-wire bus master with direct memory access and Wishbone registers
//
// How it works
// - Receive start sends start, address, read bit
// - Bytes stored from receive pointer upward
// - Acknowledge all bytes, not-acknowledge the last
// - Final-rx event when ready for last byte
// - No self stop on full buffer or error
// - Halt ignored while paused; continue first
// - Pause stretches clock after byte, then event
// - Final-byte events at byte boundaries
// - Link bits sit at positions 7 to 10 and 12
// - Set link fires its task on event; the rx-to-tx pulse arrives while busy and is lost
// - Links chain write then read with repeated start
// - Pin selects drive scl_sel_o and sda_sel_o whether enabled or not
// - Moved counts report last transaction bytes
// - Receive limit caps bytes stored only while a halt is pending
// - Bus address comes from address register
// - Fault event on any not-acknowledge clocked from the slave
// - Halted event after halt carried out
// - Pointers and limits double-buffered at start
`timescale 1ns/1ns
`default_nettype none
`include "twm_defines.svh"
module twm_master (
	// System
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [11:0] adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// Memory write port
	output logic             mem_we_o,
	output logic      [31:0] mem_adr_o,
	output logic      [7:0]  mem_dat_o,
	// Bus pins
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             scl_o,
	output logic             scl_oe_o,
	output logic             sda_o,
	output logic             sda_oe_o,
	// Pin routing
	output logic             pins_owned_o,
	output logic      [31:0] scl_sel_o,
	output logic      [31:0] sda_sel_o
);
	typedef struct packed {
		twm_pkg::twm_phase_type  ph;
		logic                    rd;
		logic [1:0]              q;
		logic [11:0]             tick;
		logic [3:0]              bitn;
		logic [7:0]              sh;
		logic                    addr_ph;
		logic                    halt_req;
		logic                    pause_req;
		logic                    paused;
		logic                    link_rx;
		logic                    link_tx;
		logic [31:0]             cnt;
		logic [31:0]             rx_ptr_a;
		logic [31:0]             rx_lim_a;
		logic [31:0]             tx_ptr_a;
		logic [31:0]             tx_lim_a;
		logic [31:0]             rx_ptr;
		logic [31:0]             rx_lim;
		logic [31:0]             tx_ptr;
		logic [31:0]             tx_lim;
		logic [31:0]             rx_moved;
		logic [31:0]             tx_moved;
		logic [6:0]              ev;
		logic [31:0]             links;
		logic [31:0]             ie;
		logic [2:0]              fault;
		logic [3:0]              en;
		logic [31:0]             scl_sel;
		logic [31:0]             sda_sel;
		logic [31:0]             rate;
		logic [6:0]              addr;
		logic [1:0]              scl_s;
		logic [1:0]              sda_s;
		twm_pkg::twm_pin_type    pin;
		twm_pkg::twm_mem_req_type mem;
		logic [31:0]             rdat;
		logic                    ack;
		logic                    owned;
	} twm_state_type;

	twm_state_type r;
	twm_state_type next_r;
	twm_pkg::twm_wb_req_type wb;

	// ------------------------------------------------------------
	// Register access decode
	// ------------------------------------------------------------
	logic acc;
	logic wr;
	logic w1;
	logic [6:0] ev_set;
	logic scl_hi;
	logic sda_in;
	logic qend;
	always_comb begin
		wb = '{cyc: cyc_i, stb: stb_i, we: we_i, adr: adr_i, dat: dat_i};
		acc = wb.cyc && wb.stb && !r.ack;
		wr = acc && wb.we && (sel_i == 4'hF);
		w1 = wr && wb.dat[0];
		scl_hi = r.scl_s[1];
		sda_in = r.sda_s[1];
		qend = (r.tick == 12'h000);
	end

	// Event index: 0 halted 1 fault 2 paused 3 rxbeg 4 txbeg 5 frx 6 ftx
	function automatic logic [31:0] rd_mux(input twm_state_type s,
			input logic [11:0] a);
		logic [31:0] v;
		v = 32'h00000000;
		case (a)
			`TWM_OFF_EV_HALTED:   v = {31'h0, s.ev[0]};
			`TWM_OFF_EV_FAULT:    v = {31'h0, s.ev[1]};
			`TWM_OFF_EV_PAUSED:   v = {31'h0, s.ev[2]};
			`TWM_OFF_EV_RX_BEGUN: v = {31'h0, s.ev[3]};
			`TWM_OFF_EV_TX_BEGUN: v = {31'h0, s.ev[4]};
			`TWM_OFF_EV_FINAL_RX: v = {31'h0, s.ev[5]};
			`TWM_OFF_EV_FINAL_TX: v = {31'h0, s.ev[6]};
			`TWM_OFF_LINKS:       v = s.links;
			`TWM_OFF_IRQ_EN,
			`TWM_OFF_IRQ_SET,
			`TWM_OFF_IRQ_CLR:     v = s.ie;
			`TWM_OFF_FAULT_CAUSE: v = {29'h0, s.fault};
			`TWM_OFF_ENABLE:      v = {28'h0, s.en};
			`TWM_OFF_SCL_SEL:     v = s.scl_sel;
			`TWM_OFF_SDA_SEL:     v = s.sda_sel;
			`TWM_OFF_RATE:        v = s.rate;
			`TWM_OFF_RX_PTR:      v = s.rx_ptr_a;
			`TWM_OFF_RX_LIMIT:    v = s.rx_lim_a;
			`TWM_OFF_RX_MOVED:    v = s.rx_moved;
			`TWM_OFF_TX_PTR:      v = s.tx_ptr_a;
			`TWM_OFF_TX_LIMIT:    v = s.tx_lim_a;
			`TWM_OFF_TX_MOVED:    v = s.tx_moved;
			`TWM_OFF_ADDR:        v = {25'h0, s.addr};
			default:              v = 32'h00000000;
		endcase
		return v;
	endfunction : rd_mux

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	logic t_rx;
	logic t_tx;
	logic t_halt;
	logic t_pause;
	logic t_cont;
	logic enabled;
	always_comb begin
		next_r = r;
		ev_set = 7'h00;
		enabled = (r.en == `TWM_ENABLE_ON);
		next_r.scl_s = {r.scl_s[0], scl_i};
		next_r.sda_s = {r.sda_s[0], sda_i};
		next_r.ack = acc;
		next_r.rdat = acc ? rd_mux(r, wb.adr) : r.rdat;
		next_r.mem.we = 1'b0;
		t_rx = (w1 && wb.adr == `TWM_OFF_TASK_RX_BEGIN) || r.link_rx;
		t_tx = (w1 && wb.adr == `TWM_OFF_TASK_TX_BEGIN) || r.link_tx;
		t_halt = w1 && wb.adr == `TWM_OFF_TASK_HALT;
		t_pause = w1 && wb.adr == `TWM_OFF_TASK_PAUSE;
		t_cont = w1 && wb.adr == `TWM_OFF_TASK_CONTINUE;
		next_r.link_rx = 1'b0;
		next_r.link_tx = 1'b0;
		if (wr) begin
			case (wb.adr)
				`TWM_OFF_LINKS:    next_r.links = wb.dat & 32'h00001780;
				`TWM_OFF_IRQ_EN:   next_r.ie = wb.dat & `TWM_IE_MASK;
				`TWM_OFF_IRQ_SET:  next_r.ie = r.ie | (wb.dat & `TWM_IE_MASK);
				`TWM_OFF_IRQ_CLR:  next_r.ie = r.ie & ~wb.dat;
				`TWM_OFF_FAULT_CAUSE: next_r.fault = r.fault & ~wb.dat[2:0];
				`TWM_OFF_ENABLE:   next_r.en = wb.dat[3:0];
				`TWM_OFF_SCL_SEL:  next_r.scl_sel = wb.dat;
				`TWM_OFF_SDA_SEL:  next_r.sda_sel = wb.dat;
				`TWM_OFF_RATE:     next_r.rate = wb.dat;
				`TWM_OFF_RX_PTR:   next_r.rx_ptr_a = wb.dat;
				`TWM_OFF_RX_LIMIT: next_r.rx_lim_a = wb.dat;
				`TWM_OFF_TX_PTR:   next_r.tx_ptr_a = wb.dat;
				`TWM_OFF_TX_LIMIT: next_r.tx_lim_a = wb.dat;
				`TWM_OFF_ADDR:     next_r.addr = wb.dat[6:0];
				`TWM_OFF_EV_HALTED:   next_r.ev[0] = wb.dat[0];
				`TWM_OFF_EV_FAULT:    next_r.ev[1] = wb.dat[0];
				`TWM_OFF_EV_PAUSED:   next_r.ev[2] = wb.dat[0];
				`TWM_OFF_EV_RX_BEGUN: next_r.ev[3] = wb.dat[0];
				`TWM_OFF_EV_TX_BEGUN: next_r.ev[4] = wb.dat[0];
				`TWM_OFF_EV_FINAL_RX: next_r.ev[5] = wb.dat[0];
				`TWM_OFF_EV_FINAL_TX: next_r.ev[6] = wb.dat[0];
				default: ;
			endcase
		end
		if (t_pause && r.ph != twm_pkg::ST_IDLE)
			next_r.pause_req = 1'b1;
		// Halt while paused is dropped on the floor
		if (t_halt && !r.paused && r.ph != twm_pkg::ST_IDLE)
			next_r.halt_req = 1'b1;
		if (t_halt && r.ph == twm_pkg::ST_IDLE)
			ev_set[0] = 1'b1;
		// Quarter-bit timer; a held-low clock freezes it
		if (r.tick != 12'h000 && !(r.pin.scl_oe == 1'b0 && !scl_hi && r.q == 2'd2))
			next_r.tick = r.tick - 12'h001;
		case (r.ph)
			twm_pkg::ST_IDLE: begin
				next_r.pin = '{scl_o: 1'b0, scl_oe: 1'b0, sda_o: 1'b0, sda_oe: 1'b0};
				if (enabled && (t_rx || t_tx)) begin
					next_r.rd = t_rx;
					next_r.rx_ptr = r.rx_ptr_a;
					next_r.rx_lim = r.rx_lim_a;
					next_r.tx_ptr = r.tx_ptr_a;
					next_r.tx_lim = r.tx_lim_a;
					next_r.cnt = 32'h0;
					ev_set[3] = t_rx;
					ev_set[4] = !t_rx;
					next_r.ph = twm_pkg::ST_START;
					next_r.q = 2'd0;
					next_r.tick = 12'(`TWM_QTR_CYC);
				end
			end
			twm_pkg::ST_START: if (qend) begin
				next_r.tick = 12'(`TWM_QTR_CYC);
				next_r.q = r.q + 2'd1;
				// Start: data falls while clock released high
				if (r.q == 2'd0) begin
					next_r.pin.scl_oe = 1'b0;
					next_r.pin.sda_oe = 1'b0;
				end else if (r.q == 2'd1) begin
					next_r.pin.sda_oe = 1'b1;
				end else if (r.q == 2'd2) begin
					next_r.pin.scl_oe = 1'b1;
				end else begin
					next_r.sh = {r.addr, r.rd};
					next_r.addr_ph = 1'b1;
					next_r.bitn = 4'd0;
					next_r.ph = twm_pkg::ST_BIT;
				end
			end
			twm_pkg::ST_BIT, twm_pkg::ST_ACK: if (qend) begin
				next_r.tick = 12'(`TWM_QTR_CYC);
				next_r.q = r.q + 2'd1;
				case (r.q)
					2'd0: begin
						if (r.ph == twm_pkg::ST_ACK)
							next_r.pin.sda_oe = r.rd && !r.addr_ph
								? (r.cnt + 32'd1 < r.rx_lim) : 1'b0;
						else
							next_r.pin.sda_oe = (r.rd && !r.addr_ph) ? 1'b0
								: !r.sh[7];
					end
					2'd1: next_r.pin.scl_oe = 1'b0;
					2'd2: begin
						if (r.ph == twm_pkg::ST_BIT) begin
							next_r.sh = {r.sh[6:0], sda_in};
						end
					end
					default: begin
						next_r.pin.scl_oe = 1'b1;
						if (r.ph == twm_pkg::ST_BIT) begin
							next_r.bitn = r.bitn + 4'd1;
							if (r.bitn == 4'd7)
								next_r.ph = twm_pkg::ST_ACK;
						end else begin
							next_r.ph = twm_pkg::ST_NEXT;
						end
					end
				endcase
				// Acknowledge sampled from slave on clock high
				if (r.q == 2'd2 && r.ph == twm_pkg::ST_ACK &&
						(r.addr_ph || !r.rd)) begin
					if (sda_in) begin
						ev_set[1] = 1'b1;
						next_r.fault = r.fault | (r.addr_ph ?
							3'(1 << `TWM_FAULT_ADDR_NACK) :
							3'(1 << `TWM_FAULT_DATA_NACK));
					end
				end
			end
			twm_pkg::ST_NEXT: begin
				next_r.pin.sda_oe = 1'b0;
				next_r.addr_ph = 1'b0;
				next_r.bitn = 4'd0;
				next_r.q = 2'd0;
				next_r.tick = 12'(`TWM_QTR_CYC);
				if (r.rd && !r.addr_ph) begin
					next_r.mem = '{we: 1'b1, adr: r.rx_ptr + r.cnt,
						dat: r.sh};
					next_r.cnt = r.cnt + 32'd1;
					next_r.rx_moved = r.cnt + 32'd1;
				end else if (!r.rd && !r.addr_ph) begin
					next_r.cnt = r.cnt + 32'd1;
					next_r.tx_moved = r.cnt + 32'd1;
				end
				// Byte boundary: announce the final byte
				if (r.rd && ((r.addr_ph && r.rx_lim == 32'd1) ||
						(!r.addr_ph && r.cnt + 32'd2 == r.rx_lim))) begin
					ev_set[5] = 1'b1;
				end
				if (!r.rd && ((r.addr_ph && r.tx_lim == 32'd1) ||
						(!r.addr_ph && r.cnt + 32'd2 == r.tx_lim)))
					ev_set[6] = 1'b1;
				// Pending halt ends the transfer; buffer end alone does not
				if (r.halt_req && !r.addr_ph && (r.rd ?
						(r.cnt + 32'd1 >= r.rx_lim) : 1'b1))
					next_r.ph = twm_pkg::ST_STOP;
				else if (r.pause_req) begin
					next_r.ph = twm_pkg::ST_HOLD;
					next_r.pause_req = 1'b0;
					next_r.paused = 1'b1;
					ev_set[2] = 1'b1;
				end else
					next_r.ph = twm_pkg::ST_BIT;
				next_r.sh = 8'hFF;
			end
			twm_pkg::ST_HOLD: begin
				// Clock held low keeps the bus
				if (t_cont) begin
					next_r.paused = 1'b0;
					next_r.ph = twm_pkg::ST_BIT;
				end
			end
			twm_pkg::ST_STOP: if (qend) begin
				next_r.tick = 12'(`TWM_QTR_CYC);
				next_r.q = r.q + 2'd1;
				if (r.q == 2'd0)
					next_r.pin.sda_oe = 1'b1;
				else if (r.q == 2'd1)
					next_r.pin.scl_oe = 1'b0;
				else if (r.q == 2'd2)
					next_r.pin.sda_oe = 1'b0;
				else
					next_r.ph = twm_pkg::ST_DONE;
			end
			twm_pkg::ST_DONE: begin
				next_r.halt_req = 1'b0;
				ev_set[0] = 1'b1;
				next_r.ph = twm_pkg::ST_IDLE;
			end
			default: next_r.ph = twm_pkg::ST_IDLE;
		endcase
		// Repeated start when the tx-to-rx link fires from an active transfer
		if (r.ph == twm_pkg::ST_NEXT && ev_set[6] && r.links[`TWM_LINK_TX_RX]) begin
			next_r.rd = 1'b1;
			next_r.ph = twm_pkg::ST_START;
			next_r.rx_ptr = r.rx_ptr_a;
			next_r.rx_lim = r.rx_lim_a;
			next_r.cnt = 32'h0;
			ev_set[3] = 1'b1;
		end
		if (r.ph == twm_pkg::ST_NEXT && ev_set[5] && r.links[`TWM_LINK_RX_TX]) begin
			next_r.link_tx = 1'b1;
		end
		if (ev_set[5] && r.links[`TWM_LINK_RX_HALT])
			next_r.halt_req = 1'b1;
		if (ev_set[6] && r.links[`TWM_LINK_TX_HALT])
			next_r.halt_req = 1'b1;
		if (ev_set[6] && r.links[`TWM_LINK_TX_PAUSE])
			next_r.pause_req = 1'b1;
		if (!enabled)
			next_r.pin = '{scl_o: 1'b0, scl_oe: 1'b0, sda_o: 1'b0, sda_oe: 1'b0};
		next_r.ev = next_r.ev | ev_set;
		next_r.owned = (next_r.en == `TWM_ENABLE_ON);
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '0;
			r.ph <= twm_pkg::ST_IDLE;
			r.scl_sel <= `TWM_SEL_RESET;
			r.sda_sel <= `TWM_SEL_RESET;
			r.rate <= `TWM_RATE_RESET;
			r.scl_s <= 2'b11;
			r.sda_s <= 2'b11;
		end else begin
			r <= next_r;
		end
	end

	always_comb begin
		dat_o = r.rdat;
		ack_o = r.ack;
		mem_we_o = r.mem.we;
		mem_adr_o = r.mem.adr;
		mem_dat_o = r.mem.dat;
		scl_o = r.pin.scl_o;
		scl_oe_o = r.pin.scl_oe;
		sda_o = r.pin.sda_o;
		sda_oe_o = r.pin.sda_oe;
		pins_owned_o = r.owned;
		scl_sel_o = r.scl_sel;
		sda_sel_o = r.sda_sel;
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_halt_paused: assert property (@(posedge clk_i) disable iff (rst_i)
		r.paused |-> r.ph == twm_pkg::ST_HOLD || r.ph == twm_pkg::ST_NEXT)
		else $error("paused outside hold");
	a_pins_off: assert property (@(posedge clk_i) disable iff (rst_i)
		(r.en != `TWM_ENABLE_ON) |=> !r.pin.scl_oe && !r.pin.sda_oe)
		else $error("pins driven while disabled");
	a_pause_event: assert property (@(posedge clk_i) disable iff (rst_i)
		(r.ph == twm_pkg::ST_NEXT && r.pause_req && !r.halt_req)
		|=> r.ev[2] && r.ph == twm_pkg::ST_HOLD)
		else $error("pause event missing");
	a_hold_clock: assert property (@(posedge clk_i) disable iff (rst_i)
		(r.ph == twm_pkg::ST_HOLD && r.en == `TWM_ENABLE_ON) |-> r.pin.scl_oe)
		else $error("clock not stretched");
	a_mem_write: assert property (@(posedge clk_i) disable iff (rst_i)
		r.mem.we |-> r.mem.adr == r.rx_ptr + r.cnt - 32'd1)
		else $error("memory address wrong");
	a_done_event: assert property (@(posedge clk_i) disable iff (rst_i)
		r.ph == twm_pkg::ST_DONE |=> r.ev[0] && r.ph == twm_pkg::ST_IDLE)
		else $error("halted event missing");
	a_moved_count: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(r.mem.we) |-> r.rx_moved == r.cnt)
		else $error("moved count wrong");
	a_wb_ack: assert property (@(posedge clk_i) disable iff (rst_i)
		(cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
		else $error("bus answer wrong");
endmodule : twm_master
`default_nettype wire

// File: tb/twm_slave_model.sv
// Behavioural two-wire slave answering reads with a counting byte pattern
`timescale 1ns/1ns
`default_nettype none
module twm_slave_model #(
	parameter logic [6:0] OWN_ADDR = 7'h2A
) (
	// Lines as seen on the wire
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	// Open-drain pulls, high pulls the line low
	output logic            scl_pull_o,
	output logic            sda_pull_o,
	// Last frame seen
	output logic [7:0]      head_o,
	output int              sent_o,
	output logic            nack_o
);
	logic [7:0] sh;

	initial begin
		scl_pull_o = 1'b0;
		sda_pull_o = 1'b0;
		head_o = 8'h00;
		sent_o = 0;
		nack_o = 1'b0;
		forever begin
			@(negedge sda_i iff scl_i === 1'b1);
			sent_o = 0;
			nack_o = 1'b0;
			repeat (8) begin
				@(posedge scl_i);
				head_o = {head_o[6:0], sda_i};
			end
			if (head_o[7:1] == OWN_ADDR) begin
				@(negedge scl_i);
				sda_pull_o = 1'b1;
				@(negedge scl_i);
				sda_pull_o = 1'b0;
				// Hold the clock low once per frame
				scl_pull_o = 1'b1;
				#2000 scl_pull_o = 1'b0;
				if (head_o[0]) begin
					do begin
						sh = 8'hC0 + sent_o[7:0];
						repeat (8) begin
							sda_pull_o = ~sh[7];
							sh = sh << 1;
							@(negedge scl_i);
						end
						sda_pull_o = 1'b0;
						@(posedge scl_i);
						nack_o = sda_i;
						sent_o++;
						@(negedge scl_i);
					end while (!nack_o);
				end
			end
		end
	end
endmodule : twm_slave_model
`default_nettype wire

// File: tb/twm_master_bench.sv
// Self-checking bench for the two-wire master
`timescale 1ns/1ns
`default_nettype none
`include "twm_defines.svh"
module twm_master_bench;
	typedef struct packed {
		logic        we;
		logic [11:0] a;
		logic [31:0] d;
	} twm_row_type;

	logic                  clk_i = 1'b0;
	logic                  rst_i = 1'b1;
	twm_pkg::twm_wb_req_type wb = '0;
	logic [3:0]            sel = 4'hF;
	logic [31:0]           dat_o;
	logic                  ack_o;
	logic                  mem_we_o;
	logic [31:0]           mem_adr_o;
	logic [7:0]            mem_dat_o;
	logic                  scl_oe_o;
	logic                  sda_oe_o;
	logic                  pins_owned_o;
	logic [31:0]           scl_sel_o;
	logic [31:0]           sda_sel_o;
	logic                  scl_o;
	logic                  sda_o;
	logic                  sp_scl;
	logic                  sp_sda;
	logic [7:0]            head;
	int                    sent;
	logic                  nack;
	wire logic             scl_w = !(scl_oe_o | sp_scl);
	wire logic             sda_w = !(sda_oe_o | sp_sda);
	logic [31:0]           madr [0:7];
	logic [7:0]            mdat [0:7];
	int                    mem_n = 0;
	int                    err_count = 0;
	int                    checks = 0;
	int                    cycles = 0;
	twm_row_type           rows [12];

	always #4 clk_i = ~clk_i;

	twm_master u_dut (
		.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(wb.cyc), .stb_i(wb.stb), .we_i(wb.we), .adr_i(wb.adr),
		.sel_i(sel), .dat_i(wb.dat), .dat_o(dat_o), .ack_o(ack_o),
		.mem_we_o(mem_we_o), .mem_adr_o(mem_adr_o), .mem_dat_o(mem_dat_o),
		.scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
		.sda_o(sda_o), .sda_oe_o(sda_oe_o), .pins_owned_o(pins_owned_o),
		.scl_sel_o(scl_sel_o), .sda_sel_o(sda_sel_o)
	);

	twm_slave_model u_slave (
		.scl_i(scl_w), .sda_i(sda_w), .scl_pull_o(sp_scl),
		.sda_pull_o(sp_sda), .head_o(head), .sent_o(sent), .nack_o(nack)
	);

	always @(posedge clk_i) begin
		cycles++;
		if (mem_we_o === 1'b1) begin
			madr[mem_n[2:0]] <= mem_adr_o;
			mdat[mem_n[2:0]] <= mem_dat_o;
			mem_n <= mem_n + 1;
		end
		if (cycles == 90000) begin
			err_count++;
			close_out();
		end
	end

	//--------------------------------------------------------------
	// Bus and check tasks
	//--------------------------------------------------------------
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out

	task automatic check(input logic ok, input string m);
		checks++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : check

	// Entered just after a rising edge; holds until ack is sampled
	task automatic wb_io(input logic w, input logic [11:0] a,
			input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		wb <= '{1'b1, 1'b1, w, a, d};
		@(posedge clk_i);
		while (ack_o !== 1'b1 && n < 50) begin
			@(posedge clk_i);
			n++;
		end
		q = dat_o;
		check(n < 50, "no bus answer");
		wb <= '0;
		@(posedge clk_i);
	endtask : wb_io

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb_io(1'b1, a, d, q);
	endtask : wr

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e,
			input string m);
		logic [31:0] q;
		wb_io(1'b0, a, 32'h0, q);
		check(q === e, m);
	endtask : rd_chk

	task automatic wait_ev(input logic [11:0] a, input string m);
		logic [31:0] q;
		int n;
		q = 32'h0;
		n = 0;
		while (q !== 32'h1 && n < 3000) begin
			repeat (20) @(posedge clk_i);
			wb_io(1'b0, a, 32'h0, q);
			n++;
		end
		check(q === 32'h1, m);
	endtask : wait_ev

	//--------------------------------------------------------------
	// Main sequence
	//--------------------------------------------------------------
	initial begin
		rows[0] = '{1'b0, `TWM_OFF_LINKS, 32'h0};
		rows[1] = '{1'b0, `TWM_OFF_IRQ_EN, 32'h0};
		rows[2] = '{1'b0, `TWM_OFF_SCL_SEL, `TWM_SEL_RESET};
		rows[3] = '{1'b0, `TWM_OFF_SDA_SEL, `TWM_SEL_RESET};
		rows[4] = '{1'b0, `TWM_OFF_RATE, `TWM_RATE_RESET};
		rows[5] = '{1'b1, `TWM_OFF_LINKS, 32'h00001780};
		rows[6] = '{1'b0, `TWM_OFF_LINKS, 32'h00001780};
		rows[7] = '{1'b1, `TWM_OFF_IRQ_SET, 32'hFFFFFFFF};
		rows[8] = '{1'b0, `TWM_OFF_IRQ_EN, `TWM_IE_MASK};
		rows[9] = '{1'b1, `TWM_OFF_IRQ_CLR, 32'h00000002};
		rows[10] = '{1'b0, `TWM_OFF_IRQ_EN, 32'h01DC0200};
		rows[11] = '{1'b0, 12'hFFC, 32'h0};
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check(scl_oe_o === 1'b0 && pins_owned_o === 1'b0, "reset pins");
		check(sda_sel_o === `TWM_SEL_RESET && scl_o === 1'b0 && sda_o === 1'b0, "pin levels");
		foreach (rows[i]) begin
			if (rows[i].we)
				wr(rows[i].a, rows[i].d);
			else
				rd_chk(rows[i].a, rows[i].d, "register row");
		end
		wr(`TWM_OFF_SCL_SEL, 32'h5);
		check(scl_sel_o === 32'h5, "clock pin select");
		$display("test registers done");

		// Paused read: halt ignored, link ends the read
		wr(`TWM_OFF_LINKS, 32'h0);
		wr(`TWM_OFF_ENABLE, {28'h0, `TWM_ENABLE_ON});
		check(pins_owned_o === 1'b1, "pins not owned");
		wr(`TWM_OFF_ADDR, 32'h2A);
		wr(`TWM_OFF_RX_PTR, 32'h100);
		wr(`TWM_OFF_RX_LIMIT, 32'h2);
		wr(`TWM_OFF_TASK_RX_BEGIN, 32'h1);
		wr(`TWM_OFF_TASK_PAUSE, 32'h1);
		wait_ev(`TWM_OFF_EV_RX_BEGUN, "rx begun");
		wr(`TWM_OFF_RX_PTR, 32'h300);
		wait_ev(`TWM_OFF_EV_PAUSED, "pause event");
		wr(`TWM_OFF_TASK_HALT, 32'h1);
		repeat (3000) @(posedge clk_i);
		check(scl_oe_o === 1'b1, "clock not held");
		rd_chk(`TWM_OFF_EV_HALTED, 32'h0, "halted while paused");
		wr(`TWM_OFF_LINKS, 32'h1 << `TWM_LINK_RX_HALT);
		wr(`TWM_OFF_TASK_CONTINUE, 32'h1);
		wait_ev(`TWM_OFF_EV_HALTED, "halted event");
		rd_chk(`TWM_OFF_EV_FINAL_RX, 32'h1, "final rx event");
		check(head === 8'h55, "address and read bit");
		check(sent == 2 && nack === 1'b1, "ack then nack");
		check(mem_n == 2, "bytes stored");
		check(madr[0] === 32'h100 && madr[1] === 32'h101, "mem addr");
		check(mdat[0] === 8'hC0 && mdat[1] === 8'hC1, "mem data");
		rd_chk(`TWM_OFF_RX_MOVED, 32'h2, "moved count");
		check(scl_oe_o === 1'b0 && sda_oe_o === 1'b0, "bus held");
		check(scl_w === 1'b1 && sda_w === 1'b1, "lines not idle");
		$display("test paused read done");

		// Address refused: fault, no stop until halt is asked
		wr(`TWM_OFF_LINKS, 32'h0);
		wr(`TWM_OFF_EV_HALTED, 32'h0);
		wr(`TWM_OFF_ADDR, 32'h11);
		wr(`TWM_OFF_RX_LIMIT, 32'h1);
		wr(`TWM_OFF_TASK_RX_BEGIN, 32'h1);
		wait_ev(`TWM_OFF_EV_FAULT, "fault event");
		rd_chk(`TWM_OFF_FAULT_CAUSE, 32'h2, "fault cause");
		repeat (3000) @(posedge clk_i);
		rd_chk(`TWM_OFF_EV_HALTED, 32'h0, "stopped by itself");
		wr(`TWM_OFF_TASK_HALT, 32'h1);
		wait_ev(`TWM_OFF_EV_HALTED, "halt after fault");
		wr(`TWM_OFF_ENABLE, 32'h0);
		check(pins_owned_o === 1'b0, "pins kept");
		$display("test refused address done");
		close_out();
	end
endmodule : twm_master_bench
`default_nettype wire
